/* File: rtl/sfr_bit_access_unit.sv */
// register file and bit manipulation engine of the cpu core
`timescale 1ns/1ns
`include "sba_params.svh"
module sfr_bit_access_unit (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic clk_en,
    input wire logic acc_valid,
    input wire sba_pkg::op_t acc_op,
    input wire sba_pkg::area_t acc_area,
    input wire logic [5:0] acc_idx,
    input wire logic [3:0] acc_bit,
    input wire logic acc_hi,
    input wire logic [15:0] acc_wdata,
    input wire logic [7:0] acc_mask,
    input wire logic acc_src_bit,
    input wire sba_pkg::fetch_t fetch_src,
    input wire logic fetch_dword,
    input wire logic [1:0] pipe_ext,
    input wire logic hw_upd_valid,
    input wire logic [5:0] hw_upd_idx,
    input wire logic [15:0] hw_upd_data,
    input wire logic [15:0] hw_upd_mask,
    input wire logic hw_set_valid,
    input wire logic [5:0] hw_set_idx,
    input wire logic [15:0] hw_set_bits,
    input wire logic br_valid,
    input wire logic br_abs,
    input wire logic [15:0] br_ip,
    input wire logic [15:0] br_seg,
    input wire logic ebc_req_wr,
    input wire logic ebc_req_fetch,
    input wire logic ebc_req_rd,
    output logic acc_busy,
    output logic acc_done,
    output logic acc_refused,
    output logic [15:0] acc_rdata,
    output logic jump_taken,
    output logic [15:0] sys_cfg,
    output logic [15:0] bus_prop,
    output logic new_area_fetch_ok,
    output logic [2:0] ebc_grant
);
    logic [15:0] mem [0:255];
    sba_pkg::state_t state_q;
    sba_pkg::op_t op_q;
    logic [7:0] addr_q;
    logic [3:0] bit_q;
    logic hi_q;
    logic [15:0] wdata_q;
    logic [7:0] mask_q;
    logic src_q;
    logic [15:0] impl_q;
    logic refuse_q;
    logic [15:0] rmw_q;
    logic [4:0] cnt_q;
    logic [7:0] last_addr_q;
    logic last_vld_q;
    logic psw_wr_q;
    logic [15:0] stage_sys_q;
    logic [15:0] stage_bus_q;
    integer i;

    // request decode: gpr numbers are relocated through the context pointer
    wire is_gpr = (acc_area == sba_pkg::AREA_GPR);
    wire [15:0] cp_word = mem[{2'b00, `SBA_CP_IDX}];
    wire [5:0] gpr_idx = 6'(cp_word[5:0] + {2'b00, acc_idx[3:0]});
    wire [5:0] phys_idx = is_gpr ? gpr_idx : acc_idx;
    wire [1:0] phys_area = is_gpr ? 2'b10 : acc_area[1:0];
    wire [7:0] acc_addr = {phys_area, phys_idx};
    wire in_sfr = (acc_area == sba_pkg::AREA_SFR);
    wire in_extended_special_registers = (acc_area == sba_pkg::AREA_EXTENDED_SPECIAL_REGISTERS);
    wire in_internal_ram = (acc_area == sba_pkg::AREA_INTERNAL_RAM);
    wire in_ext = (acc_area == sba_pkg::AREA_EXT);
    wire is_bitop = (acc_op != sba_pkg::OP_WORD_WRITE) &&
                    (acc_op != sba_pkg::OP_BYTE_WRITE) &&
                    (acc_op != sba_pkg::OP_WORD_READ);
    wire is_jump = (acc_op == sba_pkg::OP_JUMP_SET) ||
                   (acc_op == sba_pkg::OP_JUMP_CLEAR) ||
                   (acc_op == sba_pkg::OP_JUMP_THEN_CLEAR) ||
                   (acc_op == sba_pkg::OP_JUMP_NOT_THEN_SET);

    // bit addressability by area; gpr bypasses the ram boundary
    wire bit_ok = is_gpr || in_extended_special_registers ||
                  (in_sfr && acc_idx >= `SBA_SFR_BIT_BASE) ||
                  (in_internal_ram && acc_idx >= `SBA_INTERNAL_RAM_BIT_BASE);
    wire prot_hit = in_sfr && (acc_idx == `SBA_IP_IDX || acc_idx == `SBA_CSP_IDX);
    wire refuse = in_ext || prot_hit || (is_bitop && !bit_ok);
    // reserved bits are masked on read and on write-back
    wire [15:0] impl = (in_sfr && acc_idx == `SBA_PERIPH_IDX) ?
                       `SBA_PERIPH_IMPL : `SBA_ALL_ONES;
    wire [15:0] rd_word = in_ext ? `SBA_ZERO_WORD : (mem[acc_addr] & impl);

    // minimum clocks per fetch source and instruction length
    wire [4:0] t_min =
        (fetch_src == sba_pkg::FETCH_INT_MEM) ? `SBA_T_INT :
        (fetch_src == sba_pkg::FETCH_INTERNAL_RAM) ?
            (fetch_dword ? `SBA_T_INTERNAL_RAM_D : `SBA_T_INTERNAL_RAM_W) :
        (fetch_src == sba_pkg::FETCH_D16) ?
            (fetch_dword ? `SBA_T_D16_D : `SBA_T_D16_W) :
        (fetch_src == sba_pkg::FETCH_M16) ?
            (fetch_dword ? `SBA_T_M16_D : `SBA_T_M16_W) :
        (fetch_src == sba_pkg::FETCH_D8) ?
            (fetch_dword ? `SBA_T_D8_D : `SBA_T_D8_W) :
        (fetch_dword ? `SBA_T_M8_D : `SBA_T_M8_W);
    // a read right after a write of the same word, or a branch test
    // right after a status write, waits one more instruction cycle
    wire raw_hit = (last_vld_q && last_addr_q == acc_addr) ||
                   (is_jump && psw_wr_q);
    wire [4:0] t_raw = raw_hit ? `SBA_T_RAW : 5'h00;
    wire [4:0] t_pipe = pipe_ext[1] ? `SBA_T_FULL :
                        (pipe_ext[0] ? `SBA_T_HALF : 5'h00);
    wire [4:0] t_base = (t_min < `SBA_INSTR_CLKS) ? `SBA_INSTR_CLKS : t_min;
    wire [4:0] t_total = 5'(t_base + t_raw + t_pipe);

    // write phase: new bit is computed from the word latched at read time
    wire cur_bit = rmw_q[bit_q];
    wire [15:0] bit_m = `SBA_BIT0 << bit_q;
    wire taken = (op_q == sba_pkg::OP_JUMP_SET || op_q == sba_pkg::OP_JUMP_THEN_CLEAR) ?
                 cur_bit : !cur_bit;
    wire new_bit =
        (op_q == sba_pkg::OP_BIT_SET) ? 1'b1 :
        (op_q == sba_pkg::OP_BIT_CLEAR) ? 1'b0 :
        (op_q == sba_pkg::OP_BIT_AND) ? (cur_bit & src_q) :
        (op_q == sba_pkg::OP_BIT_OR) ? (cur_bit | src_q) :
        (op_q == sba_pkg::OP_BIT_XOR) ? (cur_bit ^ src_q) :
        (op_q == sba_pkg::OP_BIT_MOVE) ? src_q :
        (op_q == sba_pkg::OP_BIT_MOVE_NEG) ? !src_q :
        (op_q == sba_pkg::OP_JUMP_NOT_THEN_SET);
    wire is_word = (op_q == sba_pkg::OP_WORD_WRITE) || (op_q == sba_pkg::OP_BYTE_WRITE);
    wire is_test = (op_q == sba_pkg::OP_WORD_READ) || (op_q == sba_pkg::OP_JUMP_SET) ||
                   (op_q == sba_pkg::OP_JUMP_CLEAR);
    wire is_jmod = (op_q == sba_pkg::OP_JUMP_THEN_CLEAR) ||
                   (op_q == sba_pkg::OP_JUMP_NOT_THEN_SET);
    // target mask: only these bits are written back
    wire [15:0] tmask =
        is_word ? `SBA_ALL_ONES :
        is_test ? `SBA_ZERO_WORD :
        (op_q == sba_pkg::OP_MASKED_LOW) ? {8'h00, mask_q} :
        (op_q == sba_pkg::OP_MASKED_HIGH) ? {mask_q, 8'h00} :
        is_jmod ? (taken ? bit_m : `SBA_ZERO_WORD) :
        bit_m;
    wire [15:0] byte_val = hi_q ? {wdata_q[7:0], 8'h00} : {8'h00, wdata_q[7:0]};
    wire [15:0] rvalue =
        (op_q == sba_pkg::OP_WORD_WRITE) ? wdata_q :
        (op_q == sba_pkg::OP_BYTE_WRITE) ? byte_val :
        (op_q == sba_pkg::OP_MASKED_LOW) ? {8'h00, wdata_q[7:0]} :
        (op_q == sba_pkg::OP_MASKED_HIGH) ? {wdata_q[7:0], 8'h00} :
        {16{new_bit}};
    wire [15:0] wmask = refuse_q ? `SBA_ZERO_WORD : (tmask & impl_q);

    // live word with this cycle's hardware changes folded in, so that
    // bits set by hardware since the read phase are not overwritten
    wire upd_hit = hw_upd_valid && addr_q == {2'b00, hw_upd_idx};
    wire set_hit = hw_set_valid && addr_q == {2'b00, hw_set_idx};
    wire [15:0] live0 = mem[addr_q];
    wire [15:0] live1 = upd_hit ? ((live0 & ~hw_upd_mask) | (hw_upd_data & hw_upd_mask)) : live0;
    wire [15:0] live2 = set_hit ? (live1 | hw_set_bits) : live1;
    wire [15:0] wr_word = (live2 & ~wmask) | (rvalue & wmask);
    wire in_write = (state_q == sba_pkg::ST_WRITE);
    wire sw_we = in_write && (wmask != `SBA_ZERO_WORD);
    wire cfg_hit = sw_we && (addr_q == {2'b00, `SBA_SYSCFG_IDX} ||
                             addr_q == {2'b00, `SBA_BUSPROP_IDX});
    wire psw_hit = sw_we && addr_q == {2'b00, `SBA_PSW_IDX};
    wire finish = (in_write || state_q == sba_pkg::ST_WAIT) && cnt_q == 5'h00;
    wire [2:0] grant_d = ebc_req_wr ? `SBA_GNT_WR :
                         ebc_req_fetch ? `SBA_GNT_FETCH :
                         ebc_req_rd ? `SBA_GNT_RD : `SBA_GNT_NONE;

    // storage: hardware paths first, software write last so it wins
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            for (i = 0; i < 256; i = i + 1) begin
                mem[i] <= `SBA_RST_WORD;
            end
        end else if (clk_en) begin
            if (hw_upd_valid) begin
                mem[{2'b00, hw_upd_idx}] <= (mem[{2'b00, hw_upd_idx}] & ~hw_upd_mask) |
                                            (hw_upd_data & hw_upd_mask);
            end
            if (hw_set_valid) begin
                mem[{2'b00, hw_set_idx}] <= mem[{2'b00, hw_set_idx}] | hw_set_bits;
            end
            if (br_valid) begin
                mem[{2'b00, `SBA_IP_IDX}] <= br_ip;
                mem[{2'b00, `SBA_CSP_IDX}] <= br_seg;
            end
            if (sw_we) begin
                mem[addr_q] <= wr_word;
            end
        end
    end

    // sequencer: read phase at accept, write phase next, then pad time
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            state_q <= sba_pkg::ST_IDLE;
            cnt_q <= 5'h00;
        end else if (clk_en) begin
            unique case (state_q)
                sba_pkg::ST_IDLE: begin
                    if (acc_valid) begin
                        state_q <= sba_pkg::ST_WRITE;
                        cnt_q <= 5'(t_total - `SBA_INSTR_CLKS);
                    end
                end
                sba_pkg::ST_WRITE, sba_pkg::ST_WAIT: begin
                    if (cnt_q == 5'h00) begin
                        state_q <= sba_pkg::ST_IDLE;
                    end else begin
                        state_q <= sba_pkg::ST_WAIT;
                        cnt_q <= cnt_q - 5'h01;
                    end
                end
                default: state_q <= sba_pkg::ST_IDLE;
            endcase
        end
    end

    // request capture; the latched word is the read half of the rmw
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            op_q <= sba_pkg::OP_WORD_READ;
            addr_q <= 8'h00;
            bit_q <= 4'h0;
            hi_q <= 1'b0;
            wdata_q <= `SBA_RST_WORD;
            mask_q <= 8'h00;
            src_q <= 1'b0;
            impl_q <= `SBA_ALL_ONES;
            refuse_q <= 1'b0;
            rmw_q <= `SBA_RST_WORD;
        end else if (clk_en && state_q == sba_pkg::ST_IDLE && acc_valid) begin
            op_q <= acc_op;
            addr_q <= acc_addr;
            bit_q <= acc_bit;
            hi_q <= acc_hi;
            wdata_q <= acc_wdata;
            mask_q <= acc_mask;
            src_q <= acc_src_bit;
            impl_q <= impl;
            refuse_q <= refuse;
            rmw_q <= rd_word;
        end
    end

    // hazard history of the previous instruction
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            last_addr_q <= 8'h00;
            last_vld_q <= 1'b0;
            psw_wr_q <= 1'b0;
        end else if (clk_en && in_write) begin
            last_addr_q <= addr_q;
            last_vld_q <= sw_we;
            psw_wr_q <= psw_hit;
        end
    end

    // answers to the instruction stream
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            acc_busy <= 1'b0;
            acc_done <= 1'b0;
            acc_refused <= 1'b0;
            acc_rdata <= `SBA_RST_WORD;
            jump_taken <= 1'b0;
        end else if (clk_en) begin
            acc_busy <= (state_q == sba_pkg::ST_IDLE) ? acc_valid : !finish;
            acc_done <= finish;
            if (in_write) begin
                acc_refused <= refuse_q;
                acc_rdata <= rmw_q;
                jump_taken <= (is_test || is_jmod) && op_q != sba_pkg::OP_WORD_READ &&
                              !refuse_q && taken;
            end
        end
    end

    // configuration is staged at each instruction end and applied at the
    // next, so the instruction after a change still sees the old setup
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            stage_sys_q <= `SBA_RST_WORD;
            stage_bus_q <= `SBA_RST_WORD;
            sys_cfg <= `SBA_RST_WORD;
            bus_prop <= `SBA_RST_WORD;
        end else if (clk_en) begin
            // staged while done stands, so a two-clock instruction's own
            // write has already landed in storage
            if (acc_done) begin
                stage_sys_q <= mem[{2'b00, `SBA_SYSCFG_IDX}];
                stage_bus_q <= mem[{2'b00, `SBA_BUSPROP_IDX}];
            end
            if (finish) begin
                sys_cfg <= stage_sys_q;
                bus_prop <= stage_bus_q;
            end
        end
    end

    // code fetch into a remapped area waits for an absolute branch
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            new_area_fetch_ok <= 1'b1;
            ebc_grant <= `SBA_GNT_NONE;
        end else if (clk_en) begin
            ebc_grant <= grant_d;
            if (br_valid && br_abs) begin
                new_area_fetch_ok <= 1'b1;
            end else if (cfg_hit) begin
                new_area_fetch_ok <= 1'b0;
            end
        end
    end
endmodule

/* File: rtl/sba_params.svh */
// constants for the sfr bit access unit
// Contract
// - system config change takes effect one instruction later
// - newly mapped code fetch needs absolute branch first
// - bus window change: next instruction, no access
// - jump-clear/set alters bit only when taken
// - masked byte insert alters any bit subset
// - undefined bit reads zero, write ignored
// - bit changes are whole-word read-modify-write
// - no bit operations on external locations
// - only upper register area, extended register area, ram bit-addressable
// - general registers always bit-addressable
// - hardware-set bits survive read-modify-write
// - software write beats simultaneous hardware update
// - instruction and code segment pointers not accessible
// - status, stack, muldiv words also updated implicitly
// - byte write clears the other byte
// - reserved bits read zero, ignore writes
// - instruction cycle is two cpu clocks
// - internal memory 2/2, internal ram 6/8 clocks
// - external fetch 2/4, 3/6, 4/8, 6/12 clocks
// - internal memory time independent of length
// - raw or status-then-branch adds time
// - pipeline cases add half or full cycle
// - bus priority: write, fetch, then read
`ifndef SBA_PARAMS_SVH
`define SBA_PARAMS_SVH
`define SBA_IP_IDX 6'h00
`define SBA_CSP_IDX 6'h01
`define SBA_PSW_IDX 6'h02
`define SBA_CP_IDX 6'h05
`define SBA_SYSCFG_IDX 6'h08
`define SBA_BUSPROP_IDX 6'h09
`define SBA_PERIPH_IDX 6'h24
`define SBA_SFR_BIT_BASE 6'h20
`define SBA_INTERNAL_RAM_BIT_BASE 6'h20
`define SBA_PERIPH_IMPL 16'h001F
`define SBA_ALL_ONES 16'hFFFF
`define SBA_ZERO_WORD 16'h0000
`define SBA_RST_WORD 16'h0000
`define SBA_BIT0 16'h0001
`define SBA_INSTR_CLKS 5'h02
`define SBA_T_INT 5'h02
`define SBA_T_INTERNAL_RAM_W 5'h06
`define SBA_T_INTERNAL_RAM_D 5'h08
`define SBA_T_D16_W 5'h02
`define SBA_T_D16_D 5'h04
`define SBA_T_M16_W 5'h03
`define SBA_T_M16_D 5'h06
`define SBA_T_D8_W 5'h04
`define SBA_T_D8_D 5'h08
`define SBA_T_M8_W 5'h06
`define SBA_T_M8_D 5'h0C
`define SBA_T_RAW 5'h02
`define SBA_T_HALF 5'h01
`define SBA_T_FULL 5'h02
`define SBA_GNT_NONE 3'h0
`define SBA_GNT_WR 3'h1
`define SBA_GNT_FETCH 3'h2
`define SBA_GNT_RD 3'h4
`endif

/* File: rtl/sba_pkg.sv */
// types shared by the sfr bit access unit
package sba_pkg;
    typedef enum logic [3:0] {
        OP_WORD_WRITE = 4'h0, OP_BYTE_WRITE = 4'h1, OP_WORD_READ = 4'h2,
        OP_BIT_SET = 4'h3, OP_BIT_CLEAR = 4'h4, OP_BIT_AND = 4'h5,
        OP_BIT_OR = 4'h6, OP_BIT_XOR = 4'h7, OP_BIT_MOVE = 4'h8,
        OP_BIT_MOVE_NEG = 4'h9, OP_MASKED_LOW = 4'hA, OP_MASKED_HIGH = 4'hB,
        OP_JUMP_SET = 4'hC, OP_JUMP_CLEAR = 4'hD, OP_JUMP_THEN_CLEAR = 4'hE,
        OP_JUMP_NOT_THEN_SET = 4'hF
    } op_t;
    typedef enum logic [2:0] {
        AREA_SFR = 3'h0, AREA_EXTENDED_SPECIAL_REGISTERS = 3'h1, AREA_INTERNAL_RAM = 3'h2,
        AREA_GPR = 3'h3, AREA_EXT = 3'h4
    } area_t;
    typedef enum logic [2:0] {
        FETCH_INT_MEM = 3'h0, FETCH_INTERNAL_RAM = 3'h1, FETCH_D16 = 3'h2,
        FETCH_M16 = 3'h3, FETCH_D8 = 3'h4, FETCH_M8 = 3'h5
    } fetch_t;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00, ST_WRITE = 2'b01, ST_WAIT = 2'b10
    } state_t;
endpackage

/* File: test/sfr_bit_access_unit_properties.sv */
// assertion checker watching the sfr bit access unit ports
`timescale 1ns/1ns
module sba_checker (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic acc_valid,
    input wire sba_pkg::op_t acc_op,
    input wire sba_pkg::area_t acc_area,
    input wire logic [5:0] acc_idx,
    input wire logic br_valid,
    input wire logic br_abs,
    input wire logic ebc_req_wr,
    input wire logic ebc_req_fetch,
    input wire logic ebc_req_rd,
    input wire logic acc_busy,
    input wire logic acc_done,
    input wire logic acc_refused,
    input wire logic new_area_fetch_ok,
    input wire logic [2:0] ebc_grant
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    // a request is taken only while idle; clock enable is held high by the bench
    wire accept = acc_valid && !acc_busy && !acc_done;
    logic ref_exp_q;
    logic gpr_q;
    // remember what the pending instruction must report when it finishes
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            ref_exp_q <= 1'b0;
            gpr_q <= 1'b0;
        end else if (accept) begin
            ref_exp_q <= acc_area == sba_pkg::AREA_EXT
                || (acc_area == sba_pkg::AREA_SFR && acc_idx < 6'h02);
            gpr_q <= acc_area == sba_pkg::AREA_GPR;
        end
    end
    grant_write_first_a: assert property (ebc_req_wr |=> ebc_grant == 3'h1)
        else $error("write request not served first");
    grant_fetch_next_a: assert property (!ebc_req_wr && ebc_req_fetch
        |=> ebc_grant == 3'h2) else $error("fetch request not served before read");
    grant_read_last_a: assert property ((ebc_req_rd && !ebc_req_wr && !ebc_req_fetch)
        |=> ebc_grant == 3'h4) else $error("lone read request not served");
    min_two_clocks_a: assert property (accept |=> acc_busy && !acc_done)
        else $error("instruction shorter than one instruction cycle");
    done_in_time_a: assert property (accept |-> ##[2:16] acc_done)
        else $error("instruction did not complete in time");
    done_one_cycle_a: assert property (acc_done |=> !acc_done && !acc_busy)
        else $error("completion pulse longer than one clock");
    busy_ends_done_a: assert property ($fell(acc_busy) |-> acc_done)
        else $error("busy dropped without completion");
    refuse_ext_ptr_a: assert property (acc_done && ref_exp_q |-> acc_refused)
        else $error("external or pointer access not refused");
    gpr_bit_ok_a: assert property (acc_done && gpr_q |-> !acc_refused)
        else $error("general register access refused");
    abs_branch_a: assert property (br_valid && br_abs |=> new_area_fetch_ok)
        else $error("absolute branch did not enable new area fetch");
    cover property (accept && acc_area == sba_pkg::AREA_GPR);
    cover property (acc_done && acc_refused);
    cover property (br_valid && br_abs);
endmodule
bind sfr_bit_access_unit sba_checker chk_u (.ref_clk, .nrst, .acc_valid, .acc_op, .acc_area,
    .acc_idx, .br_valid, .br_abs, .ebc_req_wr, .ebc_req_fetch, .ebc_req_rd, .acc_busy,
    .acc_done, .acc_refused, .new_area_fetch_ok, .ebc_grant);

/* File: test/sfr_bit_access_unit_bench.sv */
// self-checking bench for the sfr bit access unit
`timescale 1ns/1ns
module sfr_bit_access_unit_bench;
    logic ref_clk = 1'b0, nrst = 1'b0, acc_valid = 1'b0, acc_hi = 1'b0, acc_src_bit = 1'b0;
    sba_pkg::op_t acc_op = sba_pkg::OP_WORD_READ;
    sba_pkg::area_t acc_area = sba_pkg::AREA_INTERNAL_RAM;
    sba_pkg::fetch_t fetch_src = sba_pkg::FETCH_INT_MEM;
    logic [5:0] acc_idx = 6'h00, hw_upd_idx = 6'h00, hw_set_idx = 6'h00;
    logic [3:0] acc_bit = 4'h0;
    logic [7:0] acc_mask = 8'h00;
    logic [1:0] pipe_ext = 2'h0;
    logic [15:0] acc_wdata = 16'h0000, hw_upd_data = 16'h0000, hw_upd_mask = 16'h0000;
    logic [15:0] hw_set_bits = 16'h0000, br_ip = 16'h0000, br_seg = 16'h0000, w, v;
    logic fetch_dword = 1'b0, hw_upd_valid = 1'b0, hw_set_valid = 1'b0;
    logic br_valid = 1'b0, br_abs = 1'b0, ebc_req_wr = 1'b0, ebc_req_fetch = 1'b0;
    logic ebc_req_rd = 1'b0, acc_busy, acc_done, acc_refused, jump_taken, new_area_fetch_ok;
    logic [15:0] acc_rdata, sys_cfg, bus_prop, stg_sys = 16'h0000, stg_bus = 16'h0000;
    logic [2:0] ebc_grant;
    logic [15:0] mem [256] = '{default: 16'h0000};
    logic fok = 1'b1;
    logic [31:0] rng = 32'h000093D0;
    int fails = 0, check_count = 0, n, t_exp, prev_k = -1, prev_wr = 0;
    always #25 ref_clk = ~ref_clk;
    // clock enable is the only tied input; freezing is not exercised
    sfr_bit_access_unit dut_u (.ref_clk, .nrst, .clk_en(1'b1), .acc_valid, .acc_op, .acc_area,
        .acc_idx, .acc_bit, .acc_hi, .acc_wdata, .acc_mask, .acc_src_bit, .fetch_src,
        .fetch_dword, .pipe_ext, .hw_upd_valid, .hw_upd_idx, .hw_upd_data, .hw_upd_mask,
        .hw_set_valid, .hw_set_idx, .hw_set_bits, .br_valid, .br_abs, .br_ip, .br_seg,
        .ebc_req_wr, .ebc_req_fetch, .ebc_req_rd, .acc_busy, .acc_done, .acc_refused,
        .acc_rdata, .jump_taken, .sys_cfg, .bus_prop, .new_area_fetch_ok, .ebc_grant);
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    function automatic logic [15:0] rnd();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng[15:0];
    endfunction
    // general registers land in internal ram relative to the context pointer word
    function automatic int key(sba_pkg::area_t ar, logic [5:0] idx);
        logic [5:0] g;
        g = mem[5][5:0] + {2'b00, idx[3:0]};
        return (ar == sba_pkg::AREA_GPR) ? {2'b10, g} : {ar[1:0], idx};
    endfunction
    // one instruction against the model; hw_mode 1 or 2 pulses hardware at the write edge
    task automatic run(sba_pkg::op_t op, sba_pkg::area_t ar, logic [5:0] idx,
            logic [15:0] wd = 16'h0000, logic [3:0] bt = 4'h0, logic [7:0] mk = 8'h00,
            logic src = 1'b0, int hw_mode = 0);
        int k, tw[6], td[6];
        logic [15:0] old, sw, tm;
        logic bad, b, nb, jt;
        tw = '{2, 6, 2, 3, 4, 6};
        td = '{2, 8, 4, 6, 8, 12};
        k = key(ar, idx);
        old = mem[k];
        b = old[bt];
        jt = 1'b0;
        nb = op == sba_pkg::OP_BIT_SET || op == sba_pkg::OP_JUMP_NOT_THEN_SET;
        bad = ar == sba_pkg::AREA_EXT || (ar == sba_pkg::AREA_SFR && idx < 6'h02)
            || (op inside {[sba_pkg::OP_BIT_SET:sba_pkg::OP_JUMP_NOT_THEN_SET]}
            && ar inside {sba_pkg::AREA_SFR, sba_pkg::AREA_INTERNAL_RAM} && idx < 6'h20);
        case (op)
            sba_pkg::OP_BIT_AND: nb = b & src;
            sba_pkg::OP_BIT_OR: nb = b | src;
            sba_pkg::OP_BIT_XOR: nb = b ^ src;
            sba_pkg::OP_BIT_MOVE: nb = src;
            sba_pkg::OP_BIT_MOVE_NEG: nb = !src;
            sba_pkg::OP_JUMP_SET, sba_pkg::OP_JUMP_THEN_CLEAR: jt = b;
            sba_pkg::OP_JUMP_CLEAR, sba_pkg::OP_JUMP_NOT_THEN_SET: jt = !b;
            default: ;
        endcase
        // single-bit ops touch one bit of the whole word; jump-then-clear/set write only when taken, plain jump tests never write
        tm = 16'h0001 << bt;
        sw = {15'h0000, nb} << bt;
        if (op inside {sba_pkg::OP_WORD_READ, sba_pkg::OP_JUMP_SET, sba_pkg::OP_JUMP_CLEAR}
            || (op >= sba_pkg::OP_JUMP_THEN_CLEAR && !jt)) tm = 16'h0000;
        if (op <= sba_pkg::OP_BYTE_WRITE) tm = 16'hFFFF;
        if (op == sba_pkg::OP_WORD_WRITE) sw = wd;
        if (op == sba_pkg::OP_BYTE_WRITE) sw = bt[0] ? {wd[7:0], 8'h0} : {8'h0, wd[7:0]};
        if (op == sba_pkg::OP_MASKED_LOW) {tm, sw} = {8'h00, mk, 8'h00, wd[7:0]};
        if (op == sba_pkg::OP_MASKED_HIGH) {tm, sw} = {mk, 8'h00, wd[7:0], 8'h00};
        t_exp = (fetch_dword ? td[fetch_src] : tw[fetch_src]) + (pipe_ext[1] ? 2 : pipe_ext[0]);
        if (prev_wr && (prev_k == k || (op >= sba_pkg::OP_JUMP_SET && prev_k == 2))) t_exp += 2;
        acc_op = op;
        acc_area = ar;
        {acc_valid, acc_idx, acc_wdata} = {1'b1, idx, wd};
        {acc_bit, acc_hi, acc_mask} = {bt, bt[0], mk};
        acc_src_bit = src;
        @(negedge ref_clk);
        acc_valid = 1'b0;
        hw_upd_valid = hw_mode == 1;
        hw_set_valid = hw_mode == 2;
        @(negedge ref_clk);
        hw_upd_valid = 1'b0;
        hw_set_valid = 1'b0;
        if (hw_mode == 1)
            mem[hw_upd_idx] = (mem[hw_upd_idx] & ~hw_upd_mask) | (hw_upd_data & hw_upd_mask);
        if (hw_mode == 2) mem[hw_set_idx] |= hw_set_bits;
        if (!bad) mem[k] = (mem[k] & ~tm) | (sw & tm);
        if (k == 8'h24) mem[k] &= 16'h001F;
        n = 2;
        while (acc_done !== 1'b1 && n < 40) begin
            @(negedge ref_clk);
            n++;
        end
        check("done time", 16'(n), 16'(t_exp));
        check("refused", acc_refused, bad);
        if (!bad) check("read data", acc_rdata, old);
        check("jump", jump_taken, jt && !bad);
        prev_k = k;
        prev_wr = !bad && tm != 0;
        @(negedge ref_clk);
        check("sys cfg", sys_cfg, stg_sys);
        check("bus prop", bus_prop, stg_bus);
        stg_sys = mem[8];
        stg_bus = mem[9];
        if (prev_wr && (k == 8 || k == 9)) fok = 1'b0;
        else check("fetch ok", new_area_fetch_ok, fok);
    endtask
    task automatic branch(logic ab);
        {br_valid, br_abs, br_ip, br_seg} = {1'b1, ab, rnd(), rnd()};
        @(negedge ref_clk);
        br_valid = 1'b0;
        @(negedge ref_clk);
        fok = fok | ab;
        check("fetch ok", new_area_fetch_ok, fok);
    endtask
    // hang guard, far beyond the under two thousand cycles the sequence needs
    initial begin
        #2000000;
        fails++;
        finish_test();
    end
    initial begin
        repeat (2) @(negedge ref_clk);
        nrst = 1'b1;
        for (int i = 0; i < 8; i++) begin
            {ebc_req_wr, ebc_req_fetch, ebc_req_rd} = i[2:0];
            @(negedge ref_clk);
            check("grant", ebc_grant, i[2] ? 1 : i[1] ? 2 : i[0] ? 4 : 0);
        end
        {ebc_req_wr, ebc_req_fetch, ebc_req_rd} = 3'h0;
        run(sba_pkg::OP_WORD_WRITE, sba_pkg::AREA_SFR, 6'h08, 16'h1234);
        run(sba_pkg::OP_WORD_WRITE, sba_pkg::AREA_SFR, 6'h09, 16'hA5A5);
        run(sba_pkg::OP_WORD_READ, sba_pkg::AREA_INTERNAL_RAM, 6'h20);
        branch(1'b0);
        branch(1'b1);
        run(sba_pkg::OP_WORD_WRITE, sba_pkg::AREA_SFR, 6'h00, 16'hFFFF);
        run(sba_pkg::OP_WORD_READ, sba_pkg::AREA_SFR, 6'h01);
        run(sba_pkg::OP_BIT_SET, sba_pkg::AREA_EXT, 6'h30);
        run(sba_pkg::OP_WORD_WRITE, sba_pkg::AREA_SFR, 6'h24, 16'hFFFF);
        run(sba_pkg::OP_WORD_READ, sba_pkg::AREA_SFR, 6'h24);
        run(sba_pkg::OP_BIT_SET, sba_pkg::AREA_SFR, 6'h24, 16'h0000, 4'h9);
        run(sba_pkg::OP_BYTE_WRITE, sba_pkg::AREA_SFR, 6'h30, 16'h5A5A, 4'h1);
        run(sba_pkg::OP_BYTE_WRITE, sba_pkg::AREA_SFR, 6'h30, 16'h5A5A, 4'h0);
        run(sba_pkg::OP_WORD_WRITE, sba_pkg::AREA_SFR, 6'h10, 16'h00F0);
        run(sba_pkg::OP_BIT_CLEAR, sba_pkg::AREA_SFR, 6'h10, 16'h0000, 4'h4);
        run(sba_pkg::OP_WORD_WRITE, sba_pkg::AREA_SFR, 6'h05, 16'h0010);
        run(sba_pkg::OP_BIT_SET, sba_pkg::AREA_GPR, 6'h03, 16'h0000, 4'h2);
        run(sba_pkg::OP_WORD_READ, sba_pkg::AREA_INTERNAL_RAM, 6'h13);
        {hw_set_idx, hw_set_bits} = {6'h30, 16'h8000};
        {hw_upd_idx, hw_upd_data, hw_upd_mask} = {6'h30, 16'h0000, 16'hFFFF};
        run(sba_pkg::OP_BIT_SET, sba_pkg::AREA_SFR, 6'h30, 16'h0000, 4'h0, 8'h00, 1'b0, 2);
        run(sba_pkg::OP_BIT_SET, sba_pkg::AREA_SFR, 6'h30, 16'h0000, 4'h3, 8'h00, 1'b0, 1);
        {hw_upd_idx, hw_upd_data, hw_upd_mask} = {6'h02, 16'h00C3, 16'h00FF};
        run(sba_pkg::OP_WORD_READ, sba_pkg::AREA_INTERNAL_RAM, 6'h20, 16'h0000, 4'h0, 8'h00, 1'b0, 1);
        run(sba_pkg::OP_WORD_READ, sba_pkg::AREA_SFR, 6'h02);
        run(sba_pkg::OP_WORD_WRITE, sba_pkg::AREA_SFR, 6'h02, 16'h0001);
        run(sba_pkg::OP_JUMP_SET, sba_pkg::AREA_INTERNAL_RAM, 6'h21);
        // random ops on bit-addressable ram, all fetch sources and pipeline stretches
        for (int i = 0; i < 100; i++) begin
            w = rnd();
            v = rnd();
            fetch_src = sba_pkg::fetch_t'(v % 6);
            {fetch_dword, pipe_ext} = v[15:13];
            run(sba_pkg::op_t'(v[3:0]), sba_pkg::AREA_INTERNAL_RAM, 6'h20 + v[5:4], {w[7:0], w[7:0]},
                w[11:8], w[15:8], w[12]);
        end
        finish_test();
    end
endmodule
